// ==== hdl/spi_shift_exchange_core.sv ====
// Purpose: Eight-bit full-duplex serial shift-exchange port, host or client role.
// Assumes: Serial pins come from outside the clock domain and are synchronised here.
// Notes:   Received bytes queue in a 4-deep FIFO; the head is the data buffer.
// Overview of operation
// - One eight-bit shift register per side forms the exchange path.
// - Most significant bit leaves first; incoming bit enters the lowest position.
// - Output bit changes on the chosen clock edge, input captured on the other.
// - Same idle clock level at both ends; host shows first bit at load, before the first clock edge.
// - Each clock cycle moves one bit in each direction into the lowest position.
// - Eight bits swap both registers; further data reloads and repeats.
// - Unselected client ignores the bus and leaves its data line undriven.
// - Host output feeds client input, client output feeds host input.
// - Host write to the data buffer, while the receive queue has room, loads the shifter and starts at once.
// - Eight received bits go to the buffer, or set overrun if it is full; buffer-full and interrupt flags are set.
// - A write during a transfer is dropped, flags a collision, blocks until cleared.
module spi_shift_exchange_core
  import spi_xchg_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       role_host,
  input  wire logic       clk_idle_high,
  input  wire logic       out_on_trailing,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_write,
  output logic            tx_ready,
  output logic            busy,
  output logic [7:0]      serial_data_buffer,
  output logic            buffer_full_flag,
  input  wire logic       buffer_read,
  output logic            write_collision_flag,
  input  wire logic       collision_clear,
  output logic            port_interrupt_flag,
  input  wire logic       interrupt_clear,
  output logic            rx_overrun_flag,
  input  wire logic       overrun_clear,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  input  wire logic       sel_n_in,
  output logic            sel_n_out,
  output logic            sel_oe
);

  // Pin synchronisers; only stage [1] is looked at by any logic.
  logic [1:0]  sck_sync_q;
  logic [1:0]  sdi_sync_q;
  logic [1:0]  sel_sync_n_q;
  logic        sck_prev_q;

  host_state_t state_q;
  host_state_t state_d;
  logic [3:0]  half_q;
  logic [3:0]  half_d;
  logic [3:0]  edge_q;
  logic [3:0]  edge_d;
  logic        sck_act_q;
  logic        sck_act_d;

  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic        out_q;
  logic        out_d;
  logic [2:0]  bit_q;
  logic [2:0]  bit_d;
  logic        write_collision_flag_q;
  logic        irq_q;
  logic        ovr_q;

  wire sck_s     = sck_sync_q[1];
  wire sdi_s     = sdi_sync_q[1];
  wire sel_s_n   = sel_sync_n_q[1];
  wire tx_msb    = tx_data[7];

  // Client side edge finding on the sampled serial clock.
  wire client_sel = !role_host && !sel_s_n;
  wire cli_lead   = client_sel && (sck_s != clk_idle_high) && (sck_prev_q == clk_idle_high);
  wire cli_trail  = client_sel && (sck_s == clk_idle_high) && (sck_prev_q != clk_idle_high);

  // Host side edges come straight from the clock generator.
  wire host_run   = state_q == HOST_RUN;
  wire half_done  = (state_q != HOST_IDLE) && (half_q == HALF_LAST);
  wire host_lead  = host_run && half_done && !sck_act_q;
  wire host_trail = host_run && half_done && sck_act_q;
  wire last_edge  = host_run && half_done && (edge_q == EDGE_LAST);

  wire lead_edge    = role_host ? host_lead : cli_lead;
  wire trail_edge   = role_host ? host_trail : cli_trail;
  wire capture_edge = out_on_trailing ? lead_edge : trail_edge;
  wire change_edge  = out_on_trailing ? trail_edge : lead_edge;

  // Host reads the client's line, client reads the host's line, both on sdi.
  wire in_bit    = sdi_s;
  wire [7:0] rx_byte = shift_in(shift_q, in_bit);
  wire byte_done = capture_edge && (bit_q == BIT_LAST);

  wire rx_in_ready;
  wire host_busy   = state_q != HOST_IDLE;
  wire client_busy = client_sel && (bit_q != '0);

  // A full receive queue holds the host off; a client cannot stall the far end.
  assign busy     = role_host ? host_busy : client_busy;
  assign tx_ready = !busy && !write_collision_flag_q && (!role_host || rx_in_ready);
  wire   load     = tx_write && tx_ready;
  wire   collide  = tx_write && busy;
  wire   host_start = load && role_host;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_sync_q   <= SYNC_LO;
      sdi_sync_q   <= SYNC_LO;
      sel_sync_n_q <= SYNC_HI;
      sck_prev_q   <= 1'b0;
    end else if (clk_en) begin
      sck_sync_q   <= {sck_sync_q[0], sck_in};
      sdi_sync_q   <= {sdi_sync_q[0], sdi};
      sel_sync_n_q <= {sel_sync_n_q[0], sel_n_in};
      sck_prev_q   <= sck_s;
    end
  end

  // Host clock generator: sixteen half periods, then one idle half period
  // with select still held so the client sees the clock stop first.
  always_comb begin
    state_d   = state_q;
    half_d    = half_q;
    edge_d    = edge_q;
    sck_act_d = sck_act_q;
    unique case (state_q)
      HOST_IDLE: begin
        if (host_start) begin
          state_d   = HOST_RUN;
          half_d    = '0;
          edge_d    = '0;
          sck_act_d = 1'b0;
        end
      end
      HOST_RUN: begin
        half_d = half_done ? '0 : 4'(half_q + 1'b1);
        if (half_done) begin
          sck_act_d = !sck_act_q;
          edge_d    = 4'(edge_q + 1'b1);
        end
        if (last_edge) begin
          state_d = HOST_TAIL;
        end
      end
      HOST_TAIL: begin
        half_d = half_done ? '0 : 4'(half_q + 1'b1);
        if (half_done) begin
          state_d = HOST_IDLE;
        end
      end
    endcase
  end

  // Shifter: the change edge presents the top bit, the capture edge shifts.
  always_comb begin
    shift_d = shift_q;
    out_d   = out_q;
    bit_d   = bit_q;
    if (load) begin
      shift_d = tx_data;
      out_d   = tx_msb;
      bit_d   = '0;
    end else begin
      if (capture_edge) begin
        shift_d = rx_byte;
        bit_d   = 3'(bit_q + 1'b1);
      end
      if (change_edge) begin
        out_d = shift_q[7];
      end
      if (!role_host && sel_s_n) begin
        bit_d = '0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q   <= HOST_IDLE;
      half_q    <= '0;
      edge_q    <= '0;
      sck_act_q <= 1'b0;
      shift_q   <= SHIFT_RST;
      out_q     <= 1'b0;
      bit_q     <= '0;
    end else if (clk_en) begin
      state_q   <= state_d;
      half_q    <= half_d;
      edge_q    <= edge_d;
      sck_act_q <= sck_act_d;
      shift_q   <= shift_d;
      out_q     <= out_d;
      bit_q     <= bit_d;
    end
  end

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      write_collision_flag_q <= 1'b0;
      irq_q  <= 1'b0;
      ovr_q  <= 1'b0;
    end else if (clk_en) begin
      write_collision_flag_q <= collide || (write_collision_flag_q && !collision_clear);
      irq_q  <= byte_done || (irq_q && !interrupt_clear);
      ovr_q  <= (byte_done && !rx_in_ready) || (ovr_q && !overrun_clear);
    end
  end

  stream_fifo #(
    .WIDTH (BYTE_BITS),
    .DEPTH (RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .en        (clk_en),
    .in_valid  (byte_done),
    .in_ready  (rx_in_ready),
    .in_data   (rx_byte),
    .out_valid (buffer_full_flag),
    .out_ready (buffer_read),
    .out_data  (serial_data_buffer)
  );

  assign write_collision_flag = write_collision_flag_q;
  assign port_interrupt_flag  = irq_q;
  assign rx_overrun_flag      = ovr_q;

  // Pins: a single select output, so no two clients can be chosen at once.
  assign sck_out   = role_host ? (clk_idle_high ^ sck_act_q) : clk_idle_high;
  assign sck_oe    = role_host;
  assign sel_n_out = !(role_host && host_busy);
  assign sel_oe    = role_host;
  assign sdo       = out_q;
  assign sdo_oe    = role_host || client_sel;

  // Helper for checking: leading clock edges seen in one host transfer.
  logic [3:0] lead_cnt_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lead_cnt_q <= '0;
    end else if (clk_en) begin
      if (host_start) begin
        lead_cnt_q <= '0;
      end else if (host_lead) begin
        lead_cnt_q <= 4'(lead_cnt_q + 1'b1);
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_start;
    host_start && clk_en && !busy;
  endsequence

  sequence s_idle_half;
    (sck_out == clk_idle_high && !sel_n_out) [*7];
  endsequence

  sequence s_last_edge;
    last_edge && clk_en;
  endsequence

  sequence s_sel_held;
    (!sel_n_out && state_q != HOST_RUN) [*7];
  endsequence

  chk_sel_quiet: assert property ((!role_host && sel_s_n && !load && clk_en) |-> !sdo_oe ##1 $stable(shift_q))
    else $error("unselected client drives its data line or shifts");

  chk_msb_first: assert property ((load && clk_en) |=> (sdo == $past(tx_msb)))
    else $error("first output bit is not the written MSB");

  chk_lsb_in: assert property ((capture_edge && !load && clk_en) |=> (shift_q[0] == $past(in_bit)))
    else $error("captured bit not stored in lowest position");

  chk_count_clear: assert property ((!role_host && sel_s_n && clk_en) |=> (bit_q == '0))
    else $error("bit count not cleared on deselect");

  chk_byte_flags: assert property ((byte_done && rx_in_ready && clk_en) |=> (port_interrupt_flag && buffer_full_flag))
    else $error("completed byte did not set buffer and interrupt flags");

  chk_write_collide: assert property ((tx_write && busy && clk_en) |=> (write_collision_flag && !tx_ready))
    else $error("write during transfer not flagged as collision");

  chk_host_start: assert property (s_start |=> (host_busy and s_idle_half))
    else $error("host write did not start a transfer with idle lead-in");

  chk_eight_pulses: assert property ((state_q == HOST_TAIL) |-> (lead_cnt_q == LEADS_FULL))
    else $error("host issued other than eight clock pulses");

  chk_clock_then_sel: assert property (s_last_edge |=> s_sel_held)
    else $error("select released before clock stopped");

  chk_idle_level: assert property ((role_host && state_q != HOST_RUN) |-> (sck_out == clk_idle_high))
    else $error("serial clock not at idle level outside transfer");

  chk_edges_apart: assert property ((change_edge && clk_en) |=> (!capture_edge) [*3])
    else $error("capture too close to the change edge");

endmodule

// ==== pkg/spi_xchg_pkg.sv ====
// Purpose: Shared constants, state type and helpers for the serial shift-exchange core.
// Assumes: System clock of 10 MHz; serial clock generated by this core when it is the host.
// Notes:   Only the half-period count is derived from a time and the clock period; the edge, bit and lead limits come from BYTE_BITS.
package spi_xchg_pkg;

  localparam int unsigned BYTE_BITS     = 8;
  localparam int unsigned SYS_CLK_NS    = 100;
  // Half period of the generated serial clock; long enough for the far end's
  // answer to cross two synchroniser stages at both ends before it is sampled.
  localparam int unsigned SCK_HALF_NS   = 800;
  localparam int unsigned SCK_HALF_CYC  = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned RX_FIFO_DEPTH = 4;

  localparam logic [3:0] HALF_LAST  = 4'(SCK_HALF_CYC - 1);
  localparam logic [3:0] EDGE_LAST  = 4'(2 * BYTE_BITS - 1);
  localparam logic [2:0] BIT_LAST   = 3'(BYTE_BITS - 1);
  localparam logic [3:0] LEADS_FULL = 4'(BYTE_BITS);

  localparam logic [7:0] SHIFT_RST  = 8'h00;
  localparam logic [1:0] SYNC_LO    = 2'h0;
  localparam logic [1:0] SYNC_HI    = 2'h3;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_RUN,
    HOST_TAIL
  } host_state_t;

  function automatic logic [7:0] shift_in(input logic [7:0] value, input logic bit_in);
    return {value[6:0], bit_in};
  endfunction

endpackage

// ==== hdl/stream_fifo.sv ====
// Purpose: Small valid/ready FIFO holding received bytes.
// Assumes: DEPTH is a power of two; one push and one pop may happen in the same cycle.
// Notes:   Storage has no reset; only pointers and the count are reset.
module stream_fifo
  import spi_xchg_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [PW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = cnt_q != CNT_FULL;
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];

  always_ff @(posedge clk_sys) begin
    if (en && push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (en) begin
      if (push) begin
        wp_q <= PW'(wp_q + 1'b1);
      end
      if (pop) begin
        rp_q <= PW'(rp_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= (PW + 1)'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= (PW + 1)'(cnt_q - 1'b1);
      end
    end
  end

endmodule

// ==== bench/spi_peer_model.sv ====
// Purpose: Behavioural far end of the serial exchange core, as client or as host.
// Assumes: One peer on the bus; as host it makes an 800 ns serial clock of its own.
// Notes:   A released data line shows the inverse of its last bit, never a held copy.
module spi_peer_model (
  input  wire logic peer_is_host,
  input  wire logic idle_high,
  input  wire logic trail,
  input  wire logic sck_line,
  input  wire logic sel_n_line,
  input  wire logic sdi_line,
  output logic      sdo_line,
  output logic      sck_drv,
  output logic      sel_n_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  logic       act = 1'b0;
  logic       out_q = 1'b0;
  initial sel_n_drv = 1'b1;
  assign sck_drv  = idle_high ^ act;
  assign sdo_line = (peer_is_host || !sel_n_line) ? out_q : !out_q;
  always @(negedge sel_n_line) out_q = sh[7];
  always @(sck_line) begin
    if (sel_n_line === 1'b0) begin
      // Level read here, not through a net, so the edge kind cannot race the update
      if ((sck_line != idle_high) === trail) sh = {sh[6:0], sdi_line};
      else out_q = sh[7];
    end
  end
  task automatic load(input logic [7:0] b);
    sh = b;
  endtask
  // Only this side opens a frame; a partial byte happens only when a test asks for it
  task automatic run_host(input int unsigned edges, input logic sel);
    sel_n_drv = !sel;
    #1637;
    repeat (edges) begin
      #400;
      act = !act;
    end
    #400;
    sel_n_drv = 1'b1;
    #800;
  endtask
endmodule

// ==== bench/spi_shift_exchange_core_tb.sv ====
// Purpose: Self-checking bench for the serial exchange core in host and client role.
// Assumes: Peer model on the far side; clock enable held on throughout.
// Notes:   Expected bytes queue in the order the receive buffer must hand them out.
module spi_shift_exchange_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] pat_a [5] = '{8'h96, 8'h3C, 8'h81, 8'h7E, 8'h5A};
  localparam logic [7:0] pat_b [5] = '{8'hC5, 8'h12, 8'hFE, 8'h69, 8'hB0};
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       role_host = 1'b1;
  logic       clk_idle_high = 1'b0;
  logic       out_on_trailing = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic       tx_write = 1'b0;
  logic       buffer_read = 1'b0;
  logic       collision_clear = 1'b0;
  logic       interrupt_clear = 1'b0;
  logic       overrun_clear = 1'b0;
  logic       tx_ready, busy, buffer_full_flag, write_collision_flag, port_interrupt_flag, rx_overrun_flag;
  logic [7:0] serial_data_buffer;
  logic       sck_out, sck_oe, sdo, sdo_oe, sel_n_out, sel_oe;
  wire        sck_line, sel_n_line, dut_sdi, peer_sdi, peer_sck, peer_sel_n;
  int         mismatches = 0;
  int         checked = 0;
  logic [7:0] expq [$];

  always #50 clk_sys = !clk_sys;
  assign sck_line   = sck_oe ? sck_out : peer_sck;
  assign sel_n_line = sel_oe ? sel_n_out : peer_sel_n;
  // No keeper on this line: an undriven bit reaches the peer as high impedance (z)
  assign peer_sdi   = sdo_oe ? sdo : 1'bz;

  spi_shift_exchange_core i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .role_host(role_host),
    .clk_idle_high(clk_idle_high), .out_on_trailing(out_on_trailing), .tx_data(tx_data), .tx_write(tx_write),
    .tx_ready(tx_ready), .busy(busy), .serial_data_buffer(serial_data_buffer), .buffer_full_flag(buffer_full_flag),
    .buffer_read(buffer_read), .write_collision_flag(write_collision_flag), .collision_clear(collision_clear),
    .port_interrupt_flag(port_interrupt_flag), .interrupt_clear(interrupt_clear), .rx_overrun_flag(rx_overrun_flag),
    .overrun_clear(overrun_clear), .sck_in(sck_line), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(dut_sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .sel_n_in(sel_n_line), .sel_n_out(sel_n_out), .sel_oe(sel_oe));

  spi_peer_model i_peer (.peer_is_host(!role_host), .idle_high(clk_idle_high), .trail(out_on_trailing),
    .sck_line(sck_line), .sel_n_line(sel_n_line), .sdi_line(peer_sdi), .sdo_line(dut_sdi),
    .sck_drv(peer_sck), .sel_n_drv(peer_sel_n));

  task automatic complete_run;
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_idle;
    int unsigned n = 0;
    @(posedge clk_sys);
    #1;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (busy !== 1'b0) begin
      mismatches++;
      complete_run();
    end
  endtask

  // One whole byte each way; d goes out of the core, p comes back from the peer
  task automatic xfer(input logic host, input logic [1:0] mode, input logic [7:0] d, input logic [7:0] p);
    @(posedge clk_sys);
    role_host <= host;
    clk_idle_high <= mode[1];
    out_on_trailing <= mode[0];
    repeat (4) @(posedge clk_sys);
    i_peer.load(p);
    tx_data <= d;
    tx_write <= 1'b1;
    @(posedge clk_sys);
    tx_write <= 1'b0;
    if (host) begin
      wait_idle();
    end else begin
      i_peer.run_host(16, 1'b1);
      repeat (8) @(posedge clk_sys);
    end
    chk("peer_rx", d, i_peer.sh);
    if (expq.size() < 4) expq.push_back(p);
  endtask

  task automatic drain;
    while (expq.size() > 0) begin
      @(posedge clk_sys);
      #1;
      chk("buffer_full_flag", 1'b1, buffer_full_flag);
      chk("serial_data_buffer", expq.pop_front(), serial_data_buffer);
      @(posedge clk_sys);
      buffer_read <= 1'b1;
      @(posedge clk_sys);
      buffer_read <= 1'b0;
    end
    @(posedge clk_sys);
    #1;
    chk("buffer_full_flag", 1'b0, buffer_full_flag);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("busy", 1'b0, busy);
    chk("sel_n_out", 1'b1, sel_n_out);
    chk("port_interrupt_flag", 1'b0, port_interrupt_flag);
    for (int m = 0; m < 4; m++) xfer(1'b1, 2'(m), pat_a[m], pat_b[m]);
    chk("tx_ready", 1'b0, tx_ready);
    chk("port_interrupt_flag", 1'b1, port_interrupt_flag);
    drain();
    @(posedge clk_sys);
    interrupt_clear <= 1'b1;
    @(posedge clk_sys);
    interrupt_clear <= 1'b0;
    #1;
    chk("port_interrupt_flag", 1'b0, port_interrupt_flag);
    // Second write lands one cycle after the first is taken, mid-transfer
    i_peer.load(8'hC3);
    @(posedge clk_sys);
    tx_data <= 8'h4D;
    tx_write <= 1'b1;
    @(posedge clk_sys);
    tx_data <= 8'hFF;
    @(posedge clk_sys);
    tx_write <= 1'b0;
    wait_idle();
    chk("write_collision_flag", 1'b1, write_collision_flag);
    chk("tx_ready", 1'b0, tx_ready);
    chk("peer_rx", 8'h4D, i_peer.sh);
    expq.push_back(8'hC3);
    @(posedge clk_sys);
    tx_write <= 1'b1;
    @(posedge clk_sys);
    tx_write <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("busy", 1'b0, busy);
    @(posedge clk_sys);
    collision_clear <= 1'b1;
    @(posedge clk_sys);
    collision_clear <= 1'b0;
    #1;
    chk("write_collision_flag", 1'b0, write_collision_flag);
    xfer(1'b1, 2'd0, 8'h18, 8'hE7);
    drain();
    // Client role: clocks while unselected, then a broken partial frame
    @(posedge clk_sys);
    role_host <= 1'b0;
    clk_idle_high <= 1'b0;
    out_on_trailing <= 1'b0;
    i_peer.run_host(16, 1'b0);
    chk("busy", 1'b0, busy);
    chk("buffer_full_flag", 1'b0, buffer_full_flag);
    chk("sdo_oe", 1'b0, sdo_oe);
    chk("sck_oe", 1'b0, sck_oe);
    chk("sel_oe", 1'b0, sel_oe);
    i_peer.run_host(6, 1'b1);
    for (int m = 0; m < 5; m++) xfer(1'b0, 2'(m % 4), pat_b[m], pat_a[m]);
    chk("rx_overrun_flag", 1'b1, rx_overrun_flag);
    @(posedge clk_sys);
    overrun_clear <= 1'b1;
    @(posedge clk_sys);
    overrun_clear <= 1'b0;
    #1;
    chk("rx_overrun_flag", 1'b0, rx_overrun_flag);
    drain();
    complete_run();
  end
endmodule
